// >>> verilog/eeprom_select_protect_por.sv
// select-code match, write inhibit and power-on reset front end of an eeprom
`timescale 1ns/100ps
`default_nettype none

// ==========================================================================
// two flip-flop synchroniser for a pin or a foreign-domain level
module sync_two_flop #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] nxt_meta;
	logic [WIDTH-1:0] nxt_dout;

	always_comb begin
		nxt_meta = din;
		nxt_dout = meta_ff;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			dout <= '0;
		end else begin
			meta_ff <= nxt_meta;
			dout <= nxt_dout;
		end
	end
endmodule

// ==========================================================================
// top: link capture on the serial clock, framing on the system clock
module eeprom_select_protect_por
	import eeprom_front_pkg::*;
#(
	parameter bit HAS_STRAPS = 1'b1
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic serialClk,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	input wire logic [2:0] chipSelectStrap,
	input wire logic writeInhibitInput,
	input wire logic supplyOk,
	input wire logic writeBusy,
	output logic standby,
	output logic selected,
	output logic readSelected,
	output logic writeStart,
	output logic [15:0] address,
	output rxByte_t rxByte
);
	// ======================================================================
	// link domain: one sample per rising serial clock edge
	logic linkBit_ff;
	logic linkToggle_ff;
	logic nxt_linkBit;
	logic nxt_linkToggle;

	always_comb begin
		nxt_linkBit = sdaIn;
		nxt_linkToggle = ~linkToggle_ff;
	end

	// serial clock may stop between frames; nothing here waits on it
	always_ff @(posedge serialClk or posedge rst) begin
		if (rst) begin
			linkBit_ff <= 1'b0;
			linkToggle_ff <= 1'b0;
		end else begin
			linkBit_ff <= nxt_linkBit;
			linkToggle_ff <= nxt_linkToggle;
		end
	end

	// ======================================================================
	// crossings into the system domain
	pinPair_t pinS;
	logic toggleS;
	logic [2:0] strapS;
	logic inhibitS;
	logic supplyS;

	sync_two_flop #(.WIDTH(2)) syncPins (
		.clk(sys_clk),
		.rst(rst),
		.din({serialClk, sdaIn}),
		.dout(pinS)
	);

	sync_two_flop #(.WIDTH(1)) syncToggle (
		.clk(sys_clk),
		.rst(rst),
		.din(linkToggle_ff),
		.dout(toggleS)
	);

	sync_two_flop #(.WIDTH(5)) syncLevels (
		.clk(sys_clk),
		.rst(rst),
		.din({chipSelectStrap, writeInhibitInput, supplyOk}),
		.dout({strapS, inhibitS, supplyS})
	);

	// ======================================================================
	// system domain framing
	busState_t state_ff, nxt_state;
	logic [3:0] bitCnt_ff, nxt_bitCnt;
	logic [7:0] shift_ff, nxt_shift;
	logic ackPend_ff, nxt_ackPend;
	logic sdaOe_ff, nxt_sdaOe;
	logic dataAcked_ff, nxt_dataAcked;
	logic writeMode_ff, nxt_writeMode;
	logic standby_ff, nxt_standby;
	logic selected_ff, nxt_selected;
	logic readSel_ff, nxt_readSel;
	logic writeStart_ff, nxt_writeStart;
	logic [15:0] addr_ff, nxt_addr;
	rxByte_t rx_ff, nxt_rx;
	pinPair_t pinPrev_ff, nxt_pinPrev;
	logic togglePrev_ff, nxt_togglePrev;
	logic sdaOut_ff;

	logic [2:0] strapEff;
	logic bitEvt;
	logic startEvt;
	logic stopEvt;
	logic sclFall;
	logic [7:0] byteIn;
	logic selMatch;

	// straps have pad pull-downs so an open strap samples as zero
	assign strapEff = HAS_STRAPS ? strapS : STRAP_ABSENT;
	assign bitEvt = toggleS ^ togglePrev_ff;
	// the held link sample is stable for a whole serial clock period
	assign byteIn = {shift_ff[6:0], linkBit_ff};
	assign startEvt = pinS.scl && pinPrev_ff.scl && pinPrev_ff.sda
		&& !pinS.sda;
	assign stopEvt = pinS.scl && pinPrev_ff.scl && !pinPrev_ff.sda
		&& pinS.sda;
	assign sclFall = pinPrev_ff.scl && !pinS.scl;
	assign selMatch = byteIn[SEL_TYPE_MSB:SEL_TYPE_LSB] == DEV_TYPE_MEM
		&& byteIn[SEL_STRAP_MSB:SEL_STRAP_LSB] == strapEff;

	always_comb begin
		nxt_state = state_ff;
		nxt_bitCnt = bitCnt_ff;
		nxt_shift = shift_ff;
		nxt_ackPend = ackPend_ff;
		nxt_sdaOe = sdaOe_ff;
		nxt_dataAcked = dataAcked_ff;
		nxt_writeMode = writeMode_ff;
		nxt_selected = selected_ff;
		nxt_readSel = readSel_ff;
		nxt_writeStart = 1'b0;
		nxt_addr = addr_ff;
		nxt_rx = rx_ff;
		nxt_rx.valid = 1'b0;
		nxt_pinPrev = pinS;
		nxt_togglePrev = toggleS;
		if (!supplyS) begin
			// below threshold: drop all frame state except the address and last byte, and stay quiet
			nxt_state = ST_STANDBY;
			nxt_bitCnt = BIT_ZERO;
			nxt_shift = '0;
			nxt_ackPend = 1'b0;
			nxt_sdaOe = 1'b0;
			nxt_dataAcked = 1'b0;
			nxt_writeMode = 1'b0;
			nxt_selected = 1'b0;
			nxt_readSel = 1'b0;
		end else if (stopEvt) begin
			if (writeMode_ff && dataAcked_ff) begin
				nxt_writeStart = 1'b1;
			end
			nxt_state = ST_STANDBY;
			nxt_ackPend = 1'b0;
			nxt_sdaOe = 1'b0;
			nxt_dataAcked = 1'b0;
			nxt_writeMode = 1'b0;
			nxt_selected = 1'b0;
			nxt_readSel = 1'b0;
		end else if (startEvt && !writeBusy) begin
			// busy programming means a new start is ignored; stops and the bits of a frame already under way are still seen
			nxt_state = ST_SELECT;
			nxt_bitCnt = BIT_ZERO;
			nxt_ackPend = 1'b0;
			nxt_sdaOe = 1'b0;
			nxt_dataAcked = 1'b0;
			nxt_writeMode = 1'b0;
			nxt_selected = 1'b0;
			nxt_readSel = 1'b0;
		end else begin
			if (sclFall) begin
				if (ackPend_ff) begin
					nxt_sdaOe = 1'b1;
					nxt_ackPend = 1'b0;
				end else if (sdaOe_ff && bitCnt_ff == BIT_ZERO) begin
					nxt_sdaOe = 1'b0;
				end
			end
			if (bitEvt && state_ff != ST_STANDBY) begin
				// an ack lives on into the edge that a stop rides on
				nxt_dataAcked = dataAcked_ff
					&& (bitCnt_ff == ACK_SLOT || bitCnt_ff == BIT_ZERO);
				if (bitCnt_ff == ACK_SLOT) begin
					nxt_bitCnt = BIT_ZERO;
				end else begin
					nxt_shift = byteIn;
					nxt_bitCnt = bitCnt_ff + BIT_ONE;
				end
				if (bitCnt_ff == ACK_SLOT - BIT_ONE) begin
					unique case (state_ff)
						ST_SELECT: begin
							if (selMatch) begin
								nxt_ackPend = 1'b1;
								nxt_selected = 1'b1;
								if (byteIn[SEL_RW_BIT] == RW_READ) begin
									nxt_state = ST_READ;
									nxt_readSel = 1'b1;
								end else begin
									nxt_state = ST_ADDR_HI;
									nxt_writeMode = 1'b1;
								end
							end else begin
								nxt_state = ST_STANDBY;
							end
						end
						ST_ADDR_HI: begin
							nxt_ackPend = 1'b1;
							nxt_addr[15:8] = byteIn;
							nxt_state = ST_ADDR_LO;
						end
						ST_ADDR_LO: begin
							nxt_ackPend = 1'b1;
							nxt_addr[7:0] = byteIn;
							nxt_state = ST_DATA;
						end
						ST_DATA: begin
							// inhibit is sampled per byte; open pin pulls low
							if (!inhibitS) begin
								nxt_ackPend = 1'b1;
								nxt_dataAcked = 1'b1;
								nxt_rx.data = byteIn;
								nxt_rx.valid = 1'b1;
							end
							// no ack and no byte: the array stays as it was
						end
						ST_READ, ST_STANDBY: begin
							nxt_state = state_ff;
						end
					endcase
				end
				if (state_ff == ST_DATA && inhibitS) begin
					nxt_dataAcked = 1'b0;
				end
			end
		end
		nxt_standby = nxt_state == ST_STANDBY && !writeBusy;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			state_ff <= ST_STANDBY;
			bitCnt_ff <= BIT_ZERO;
			shift_ff <= '0;
			ackPend_ff <= 1'b0;
			sdaOe_ff <= 1'b0;
			dataAcked_ff <= 1'b0;
			writeMode_ff <= 1'b0;
			standby_ff <= 1'b1;
			selected_ff <= 1'b0;
			readSel_ff <= 1'b0;
			writeStart_ff <= 1'b0;
			addr_ff <= '0;
			rx_ff <= '0;
			pinPrev_ff <= '0;
			togglePrev_ff <= 1'b0;
			sdaOut_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			bitCnt_ff <= nxt_bitCnt;
			shift_ff <= nxt_shift;
			ackPend_ff <= nxt_ackPend;
			sdaOe_ff <= nxt_sdaOe;
			dataAcked_ff <= nxt_dataAcked;
			writeMode_ff <= nxt_writeMode;
			standby_ff <= nxt_standby;
			selected_ff <= nxt_selected;
			readSel_ff <= nxt_readSel;
			writeStart_ff <= nxt_writeStart;
			addr_ff <= nxt_addr;
			rx_ff <= nxt_rx;
			pinPrev_ff <= nxt_pinPrev;
			togglePrev_ff <= nxt_togglePrev;
			sdaOut_ff <= 1'b0;
		end
	end

	// ======================================================================
	// outputs; the data pin only ever pulls low
	assign sdaOut = sdaOut_ff;
	assign sdaOe = sdaOe_ff;
	assign standby = standby_ff;
	assign selected = selected_ff;
	assign readSelected = readSel_ff;
	assign writeStart = writeStart_ff;
	assign address = addr_ff;
	assign rxByte = rx_ff;
endmodule

`default_nettype wire

// >>> verilog/eeprom_front_pkg.sv
// constants and types shared by the eeprom select, protect and reset front end
package eeprom_front_pkg;
	localparam int BYTE_BITS = 8;
	localparam logic [3:0] ACK_SLOT = 4'h8;
	localparam logic [3:0] BIT_ZERO = 4'h0;
	localparam logic [3:0] BIT_ONE = 4'h1;
	localparam int SEL_TYPE_MSB = 7;
	localparam int SEL_TYPE_LSB = 4;
	localparam int SEL_STRAP_MSB = 3;
	localparam int SEL_STRAP_LSB = 1;
	localparam int SEL_RW_BIT = 0;
	localparam logic [3:0] DEV_TYPE_MEM = 4'ha;
	localparam logic [2:0] STRAP_ABSENT = 3'h0;
	localparam logic RW_READ = 1'b1;
	localparam int SYNC_STAGES = 2;

	typedef enum {
		ST_STANDBY,
		ST_SELECT,
		ST_ADDR_HI,
		ST_ADDR_LO,
		ST_DATA,
		ST_READ
	} busState_t;

	typedef struct packed {
		logic [7:0] data;
		logic valid;
	} rxByte_t;

	typedef struct packed {
		logic scl;
		logic sda;
	} pinPair_t;
endpackage

// >>> tb/eeprom_front_asserts.sv
// concurrent checks on the eeprom front end ports
`timescale 1ns/100ps
`default_nettype none
module eeprom_front_asserts
	import eeprom_front_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic writeInhibitInput,
	input wire logic supplyOk,
	input wire logic writeBusy,
	input wire logic sdaOut,
	input wire logic sdaOe,
	input wire logic standby,
	input wire logic selected,
	input wire logic readSelected,
	input wire logic writeStart,
	input wire rxByte_t rxByte
);
	// =====
	// checks
	default clocking @(posedge sys_clk);
	endclocking
	default disable iff (rst);
	// two sync flops plus the state register, with margin
	sequence supplyLow_s;
		!supplyOk [*6];
	endsequence
	sequence ackHeld_s;
		sdaOe [*8];
	endsequence
	drain_only_a: assert property (sdaOut == 1'b0)
		else $error("data line driven high");
	por_idle_a: assert property ($fell(rst) |-> standby && !sdaOe)
		else $error("not idle after reset");
	brown_quiet_a: assert property (supplyLow_s |-> !sdaOe && !selected)
		else $error("responding below threshold");
	inhibit_write_a: assert property (writeStart |-> !writeInhibitInput)
		else $error("write started while inhibited");
	inhibit_data_a: assert property (rxByte.valid |-> !writeInhibitInput)
		else $error("data accepted while inhibited");
	stop_standby_a: assert property (writeStart && !writeBusy |=> standby)
		else $error("no standby after stop");
	dir_select_a: assert property (readSelected |-> selected)
		else $error("read without select");
	idle_quiet_a: assert property (standby |-> !selected && !sdaOe)
		else $error("idle device on bus");
	ack_hold_a: assert property ($rose(sdaOe) |-> ackHeld_s)
		else $error("ack too short");
endmodule
bind eeprom_select_protect_por eeprom_front_asserts u_eeprom_front_asserts (
	.sys_clk, .rst, .writeInhibitInput, .supplyOk, .writeBusy, .sdaOut,
	.sdaOe, .standby, .selected, .readSelected, .writeStart, .rxByte);
`default_nettype wire

// >>> tb/i2c_master_model.sv
// two-wire bus master driving the serial clock, open drain data
`timescale 1ns/100ps
`default_nettype none
module i2c_master_model (
	output logic scl,
	output logic sdaLow,
	input wire logic sdaWire
);
	// =====
	// clock idles high between frames; data changes with clock low except for the start and stop edges
	initial begin
		scl = 1'b1;
		sdaLow = 1'b0;
	end
	task automatic start_cond();
		#2.3 sdaLow = 1'b0;
		#40 scl = 1'b1;
		#40 sdaLow = 1'b1;
		#40 scl = 1'b0;
		#40;
	endtask
	task automatic stop_cond();
		sdaLow = 1'b1;
		#40 scl = 1'b1;
		#40 sdaLow = 1'b0;
		#80;
	endtask
	task automatic send_byte(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			sdaLow = !b[i];
			#40 scl = 1'b1;
			#80 scl = 1'b0;
			#40;
		end
		sdaLow = 1'b0;
		#40 scl = 1'b1;
		#40 ack = !sdaWire;
		#40 scl = 1'b0;
		#40;
	endtask
endmodule
`default_nettype wire

// >>> tb/eeprom_select_protect_por_tb.sv
// self-checking bench for the eeprom select, protect and reset front end
`timescale 1ns/100ps
`default_nettype none
module eeprom_select_protect_por_tb;
	import eeprom_front_pkg::*;
	logic sys_clk, rst, supplyOk, writeBusy, writeInhibitInput, writeStart;
	logic scl, mLow, ack;
	logic [2:0] chipSelectStrap;
	wire logic [1:0] sdaOe, selected, standby, readSelected;
	logic [7:0] lastRx;
	logic [15:0] address;
	rxByte_t rxByte;
	wire logic sdaWire;
	int failures, check_count, wsCount, rxCount;
	// pull-up on the wire; any party may pull it low
	assign sdaWire = !(mLow || sdaOe[0] || sdaOe[1]);
	eeprom_select_protect_por u_eeprom_select_protect_por (
		.sys_clk, .rst, .serialClk(scl), .sdaIn(sdaWire), .sdaOut(),
		.sdaOe(sdaOe[0]), .chipSelectStrap, .writeInhibitInput, .supplyOk,
		.writeBusy, .standby(standby[0]), .selected(selected[0]),
		.readSelected(readSelected[0]), .writeStart, .address, .rxByte);
	eeprom_select_protect_por #(.HAS_STRAPS(1'b0)) u_eeprom_fixed_strap (
		.sys_clk, .rst, .serialClk(scl), .sdaIn(sdaWire), .sdaOut(),
		.sdaOe(sdaOe[1]), .chipSelectStrap, .writeInhibitInput, .supplyOk,
		.writeBusy, .standby(standby[1]), .selected(selected[1]),
		.readSelected(readSelected[1]), .writeStart(), .address(), .rxByte());
	i2c_master_model u_i2c_master_model (.scl, .sdaLow(mLow), .sdaWire);
	// =====
	// clock, monitors and helpers
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		if (writeStart === 1'b1) wsCount++;
		if (rxByte.valid === 1'b1) begin
			rxCount++;
			lastRx = rxByte.data;
		end
	end
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		check_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("checks %0d failures %0d", check_count, failures);
		if (failures == 0 && check_count > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] b, input logic expAck);
		u_i2c_master_model.send_byte(b, ack);
		tick(1);
		check(ack, expAck);
	endtask
	task automatic go();
		u_i2c_master_model.start_cond();
	endtask
	task automatic halt();
		u_i2c_master_model.stop_cond();
		tick(2);
	endtask
	initial begin
		#100000;
		failures++;
		test_done();
	end
	// =====
	// scenarios; straps read 101 on the strapped device
	initial begin
		{rst, supplyOk, writeBusy, writeInhibitInput} = 4'h8;
		chipSelectStrap = 3'h5;
		{failures, check_count, wsCount, rxCount} = '0;
		tick(2);
		rst = 1'b0;
		tick(1);
		check({standby[0], selected[0], sdaOe[0]}, 3'h4);
		go();
		wr(8'haa, 1'b0);
		halt();
		supplyOk = 1'b1;
		tick(6);
		go();
		wr(8'haa, 1'b1);
		check(selected, 2'h1);
		wr(8'h12, 1'b1);
		wr(8'h34, 1'b1);
		wr(8'h5c, 1'b1);
		check(address, 16'h1234);
		check({rxCount[7:0], lastRx}, 16'h015c);
		halt();
		check({wsCount[7:0], 6'h0, standby}, 16'h0103);
		go();
		wr(8'ha0, 1'b1);
		check(selected, 2'h2);
		go();
		wr(8'ha8, 1'b0);
		check(standby, 2'h3);
		halt();
		writeInhibitInput = 1'b1;
		tick(4);
		go();
		wr(8'haa, 1'b1);
		wr(8'h00, 1'b1);
		wr(8'h01, 1'b1);
		wr(8'h77, 1'b0);
		halt();
		check({wsCount[7:0], rxCount[7:0]}, 16'h0101);
		writeInhibitInput = 1'b0;
		go();
		wr(8'hab, 1'b1);
		check(readSelected, 2'h1);
		halt();
		go();
		wr(8'haa, 1'b1);
		supplyOk = 1'b0;
		tick(6);
		check({selected[0], sdaOe[0]}, 2'h0);
		wr(8'h12, 1'b0);
		halt();
		supplyOk = 1'b1;
		writeBusy = 1'b1;
		tick(6);
		check(standby[0], 1'b0);
		go();
		wr(8'haa, 1'b0);
		halt();
		writeBusy = 1'b0;
		go();
		wr(8'haa, 1'b1);
		rst = 1'b1;
		tick(2);
		check({selected[0], sdaOe[0], standby[0]}, 3'h1);
		rst = 1'b0;
		tick(6);
		halt();
		go();
		wr(8'haa, 1'b1);
		halt();
		test_done();
	end
endmodule
`default_nettype wire
